// File: src/pcgs_pkg.sv
// Shared constants, types and helpers for the peripheral clock gating block
package pcgs_pkg;

  // Register byte offsets in the system control space
  localparam logic [11:0] PCGS_OFF_RUN_CFG    = 12'h060;
  localparam logic [11:0] PCGS_OFF_RUN_GATE   = 12'h108;
  localparam logic [11:0] PCGS_OFF_SLEEP_GATE = 12'h118;
  localparam logic [11:0] PCGS_OFF_DEEP_GATE  = 12'h128;
  localparam logic [11:0] PCGS_OFF_IRQ_STAT   = 12'h200;
  localparam logic [11:0] PCGS_OFF_IRQ_MASK   = 12'h204;
  localparam logic [11:0] PCGS_OFF_FAULT_INFO = 12'h208;
  localparam logic [11:0] PCGS_OFF_ACTIVE     = 12'h20c;

  // Gating register layout: ports A..E at bits 0..4, DMA at bit 13
  localparam int          PCGS_NUM_UNITS  = 6;
  localparam int          PCGS_PORT_LSB   = 0;
  localparam int          PCGS_NUM_PORTS  = 5;
  localparam int          PCGS_DMA_BIT    = 13;
  localparam int          PCGS_DMA_UNIT   = 5;
  localparam logic [31:0] PCGS_GATE_WMASK = 32'h0000201f;
  localparam logic [31:0] PCGS_GATE_RESET = 32'h00000000;

  // Run clock configuration: automatic gating enable
  localparam int          PCGS_ACG_BIT    = 27;
  localparam logic [31:0] PCGS_CFG_WMASK  = 32'h08000000;
  localparam logic [31:0] PCGS_CFG_RESET  = 32'h00000000;

  // Interrupt status bits
  localparam int          PCGS_EV_FAULT   = 0;
  localparam int          PCGS_EV_MODE    = 1;
  localparam int          PCGS_NUM_EV     = 2;
  localparam logic [1:0]  PCGS_EV_RESET   = 2'h0;

  // Saturating fault counter width and reset
  localparam logic [7:0]  PCGS_CNT_RESET  = 8'h00;
  localparam logic [7:0]  PCGS_CNT_MAX    = 8'hff;

  // Power mode of the processor
  typedef enum logic [1:0] {PCGS_RUN, PCGS_SLEEP, PCGS_DEEP} pcgs_mode_t;

  // Bus slave answer state
  typedef enum logic {PCGS_IDLE, PCGS_ANSWER} pcgs_bus_st_t;

  // Access request from the peripheral bus towards a gated unit
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [2:0] unit;
  } pcgs_req_t;

  // Packs a 32-bit gating register into the compact enable vector
  function automatic logic [5:0] pcgs_pack(input logic [31:0] r);
    pcgs_pack = {r[PCGS_DMA_BIT], r[PCGS_PORT_LSB +: PCGS_NUM_PORTS]};
  endfunction : pcgs_pack

endpackage : pcgs_pkg

// File: src/pcgs_sync2.sv
// Two flip-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/10ps
module pcgs_sync2 #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // First stage feeds only the second stage
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
        end else begin
          meta_reg[g] <= async_in[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  assign sync_out = sync_reg;

endmodule : pcgs_sync2

// File: src/pcgs_mode_mux.sv
// Selects the gating register that matches the current power mode
`timescale 1ns/10ps
module pcgs_mode_mux
  import pcgs_pkg::*;
(
  // Gating registers
  input  wire logic [31:0] run_gate,
  input  wire logic [31:0] sleep_gate,
  input  wire logic [31:0] deep_gate,
  // Mode inputs
  input  wire logic        acg_en,
  input  wire logic        sleep_now,
  input  wire logic        deep_now,
  // Result
  output pcgs_mode_t       mode,
  output logic      [5:0]  active_en
);

  // Deep sleep outranks sleep; without automatic gating run always applies
  always_comb begin
    if (deep_now) begin
      mode = PCGS_DEEP;
    end else if (sleep_now) begin
      mode = PCGS_SLEEP;
    end else begin
      mode = PCGS_RUN;
    end
    case (acg_en ? mode : PCGS_RUN)
      PCGS_SLEEP: active_en = pcgs_pack(sleep_gate);
      PCGS_DEEP:  active_en = pcgs_pack(deep_gate);
      default:    active_en = pcgs_pack(run_gate);
    endcase
  end

endmodule : pcgs_mode_mux

// File: src/pcgs_clock_gate.sv
// Clock gating controller for GPIO ports A..E and the DMA unit
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps

// Functional notes
// - Set bit clocks unit, clear bit stops it
// - Access to unclocked unit returns bus fault
// - All gating bits reset to zero
// - Run, sleep, deep register follow power mode
// - Sleep registers used only with automatic gating
// - Bits 0 to 4 enable ports A..E
// - Bit 13 enables the DMA unit
// - Reserved bits read zero, writes ignored
// - Deep sleep register at 0x128, same layout
module pcgs_clock_gate
  import pcgs_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // Power mode from the processor (asynchronous levels)
  input  wire logic        sleep_mode_in,
  input  wire logic        deep_sleep_mode_in,
  // Peripheral access check
  input  pcgs_req_t        periph_req,
  output logic             periph_fault,
  // Unit clock enables: bit 0..4 ports A..E, bit 5 DMA
  output logic      [5:0]  unit_clk_en,
  // Interrupt
  output logic             irq
);

  // Register file
  logic [31:0]        run_cfg_reg;
  logic [31:0]        run_cfg_next;
  logic [31:0]        run_gate_reg;
  logic [31:0]        run_gate_next;
  logic [31:0]        sleep_gate_reg;
  logic [31:0]        sleep_gate_next;
  logic [31:0]        deep_gate_reg;
  logic [31:0]        deep_gate_next;
  logic [1:0]         irq_stat_reg;
  logic [1:0]         irq_stat_next;
  logic [1:0]         irq_mask_reg;
  logic [1:0]         irq_mask_next;

  // Bus slave state
  pcgs_bus_st_t       bus_st_reg;
  pcgs_bus_st_t       bus_st_next;
  logic               pready_reg;
  logic               pready_next;
  logic [31:0]        prdata_reg;
  logic [31:0]        prdata_next;
  logic               pslverr_reg;
  logic               pslverr_next;

  // Enables, mode tracking and fault logging
  logic [5:0]         en_reg;
  logic [5:0]         en_next;
  pcgs_mode_t         mode_reg;
  pcgs_mode_t         mode_next;
  logic               fault_reg;
  logic               fault_next;
  logic [2:0]         fault_unit_reg;
  logic [2:0]         fault_unit_next;
  logic               fault_wr_reg;
  logic               fault_wr_next;
  logic [7:0]         fault_cnt_reg;
  logic [7:0]         fault_cnt_next;
  logic               irq_reg;
  logic               irq_next;

  // Decoded helpers
  logic [1:0]         mode_sync;
  logic [5:0]         active_en;
  pcgs_mode_t         mode_now;
  logic               setup_phase;
  logic               wr_commit;
  logic               ev_fault;
  logic               ev_mode;
  logic [1:0]         ev_set;
  logic [1:0]         ev_clr;
  logic [15:0]        fault_info;
  logic [7:0]         active_view;

  // True when the address hits one of the mapped words
  function automatic logic pcgs_mapped(input logic [11:0] a);
    case (a)
      PCGS_OFF_RUN_CFG, PCGS_OFF_RUN_GATE, PCGS_OFF_SLEEP_GATE,
      PCGS_OFF_DEEP_GATE, PCGS_OFF_IRQ_STAT, PCGS_OFF_IRQ_MASK,
      PCGS_OFF_FAULT_INFO, PCGS_OFF_ACTIVE: pcgs_mapped = 1'b1;
      default:                              pcgs_mapped = 1'b0;
    endcase
  endfunction : pcgs_mapped

  // Read mux; unwritable bits are never stored so they read zero
  function automatic logic [31:0] pcgs_read(input logic [11:0] a,
                                            input logic [31:0] cfg,
                                            input logic [31:0] rg,
                                            input logic [31:0] sg,
                                            input logic [31:0] dg,
                                            input logic [1:0]  st,
                                            input logic [1:0]  mk,
                                            input logic [15:0] fi,
                                            input logic [7:0]  act);
    case (a)
      PCGS_OFF_RUN_CFG:    pcgs_read = cfg;
      PCGS_OFF_RUN_GATE:   pcgs_read = rg;
      PCGS_OFF_SLEEP_GATE: pcgs_read = sg;
      PCGS_OFF_DEEP_GATE:  pcgs_read = dg;
      PCGS_OFF_IRQ_STAT:   pcgs_read = {30'h0, st};
      PCGS_OFF_IRQ_MASK:   pcgs_read = {30'h0, mk};
      PCGS_OFF_FAULT_INFO: pcgs_read = {16'h0, fi};
      PCGS_OFF_ACTIVE:     pcgs_read = {24'h0, act};
      default:             pcgs_read = 32'h00000000;
    endcase
  endfunction : pcgs_read

  // Mode levels come from the processor core outside this clock domain;
  // nothing reads them before the second synchroniser flop
  pcgs_sync2 #(
    .W        (2)
  ) u_sync (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .async_in ({deep_sleep_mode_in, sleep_mode_in}),
    .sync_out (mode_sync)
  );

  // Register selection by power mode
  // The mux is pure logic; the enable flops behind it remove its glitches
  pcgs_mode_mux u_mux (
    .run_gate   (run_gate_reg),
    .sleep_gate (sleep_gate_reg),
    .deep_gate  (deep_gate_reg),
    .acg_en     (run_cfg_reg[PCGS_ACG_BIT]),
    .sleep_now  (mode_sync[0]),
    .deep_now   (mode_sync[1]),
    .mode       (mode_now),
    .active_en  (active_en)
  );

  // Bus phase decode
  assign setup_phase = psel && !penable;
  assign wr_commit   = (bus_st_reg == PCGS_ANSWER) && psel && penable
                       && pwrite && pready_reg;

  // Read-only views packed once so the read mux stays a plain table
  assign fault_info  = {fault_cnt_reg, 3'h0, fault_wr_reg, 1'b0,
                        fault_unit_reg};
  // Ports D and E are left out of this view; unit_clk_en shows all six
  assign active_view = {1'b0, mode_reg[1:0], 1'b0, en_reg[5], en_reg[2:0]};

  // Bus slave: answer is prepared in setup, shown in the access cycle.
  // Zero wait states keep register access cheap; the price is that the
  // whole read mux sits in front of the prdata flop in the setup cycle.
  always_comb begin
    bus_st_next  = bus_st_reg;
    pready_next  = 1'b0;
    prdata_next  = 32'h00000000;
    pslverr_next = 1'b0;
    case (bus_st_reg)
      PCGS_IDLE: begin
        if (setup_phase) begin
          bus_st_next  = PCGS_ANSWER;
          pready_next  = 1'b1;
          pslverr_next = !pcgs_mapped(paddr);
          if (!pwrite) begin
            prdata_next = pcgs_read(paddr, run_cfg_reg, run_gate_reg,
                                    sleep_gate_reg, deep_gate_reg,
                                    irq_stat_reg, irq_mask_reg,
                                    fault_info, active_view);
          end
        end
      end
      PCGS_ANSWER: begin
        // Access cycle completes on this edge, pready drops after it
        bus_st_next = PCGS_IDLE;
      end
      default: begin
        bus_st_next = PCGS_IDLE;
      end
    endcase
  end

  // Bus answer registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bus_st_reg  <= PCGS_IDLE;
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      bus_st_reg  <= bus_st_next;
      pready_reg  <= pready_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Register writes take effect on the completing access edge only
  // Reserved gating bits are masked on the way in and never stored
  always_comb begin
    run_cfg_next    = run_cfg_reg;
    run_gate_next   = run_gate_reg;
    sleep_gate_next = sleep_gate_reg;
    deep_gate_next  = deep_gate_reg;
    irq_mask_next   = irq_mask_reg;
    ev_clr          = 2'h0;
    if (wr_commit) begin
      case (paddr)
        PCGS_OFF_RUN_CFG:    run_cfg_next    = pwdata & PCGS_CFG_WMASK;
        PCGS_OFF_RUN_GATE:   run_gate_next   = pwdata & PCGS_GATE_WMASK;
        PCGS_OFF_SLEEP_GATE: sleep_gate_next = pwdata & PCGS_GATE_WMASK;
        PCGS_OFF_DEEP_GATE:  deep_gate_next  = pwdata & PCGS_GATE_WMASK;
        PCGS_OFF_IRQ_MASK:   irq_mask_next   = pwdata[1:0];
        PCGS_OFF_IRQ_STAT:   ev_clr          = pwdata[1:0];
        default: begin
          run_cfg_next = run_cfg_reg;
        end
      endcase
    end
  end

  // All gating bits start cleared so every unit is unclocked
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      run_cfg_reg    <= PCGS_CFG_RESET;
      run_gate_reg   <= PCGS_GATE_RESET;
      sleep_gate_reg <= PCGS_GATE_RESET;
      deep_gate_reg  <= PCGS_GATE_RESET;
      irq_mask_reg   <= PCGS_EV_RESET;
    end else begin
      run_cfg_reg    <= run_cfg_next;
      run_gate_reg   <= run_gate_next;
      sleep_gate_reg <= sleep_gate_next;
      deep_gate_reg  <= deep_gate_next;
      irq_mask_reg   <= irq_mask_next;
    end
  end

  // Enables are retimed so a mode or register change switches cleanly
  // at a clock edge; the downstream gate cell latches on the low phase
  always_comb begin
    en_next   = active_en;
    mode_next = mode_now;
  end

  // Enable and mode registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      en_reg   <= 6'h00;
      mode_reg <= PCGS_RUN;
    end else begin
      en_reg   <= en_next;
      mode_reg <= mode_next;
    end
  end

  // Gated access check against the enables that the units see now;
  // the unit index is not trusted to be 0..5, higher codes always fault.
  // The count saturates rather than wraps so a flood stays visible.
  always_comb begin
    ev_fault        = 1'b0;
    fault_unit_next = fault_unit_reg;
    fault_wr_next   = fault_wr_reg;
    fault_cnt_next  = fault_cnt_reg;
    if (periph_req.valid) begin
      if (periph_req.unit > 3'(PCGS_DMA_UNIT)) begin
        ev_fault = 1'b1;
      end else begin
        ev_fault = !en_reg[periph_req.unit];
      end
    end
    fault_next = ev_fault;
    if (ev_fault) begin
      fault_unit_next = periph_req.unit;
      fault_wr_next   = periph_req.write;
      if (fault_cnt_reg != PCGS_CNT_MAX) begin
        fault_cnt_next = fault_cnt_reg + 8'h01;
      end
    end
  end

  // Fault pulse and fault log registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fault_reg      <= 1'b0;
      fault_unit_reg <= 3'h0;
      fault_wr_reg   <= 1'b0;
      fault_cnt_reg  <= PCGS_CNT_RESET;
    end else begin
      fault_reg      <= fault_next;
      fault_unit_reg <= fault_unit_next;
      fault_wr_reg   <= fault_wr_next;
      fault_cnt_reg  <= fault_cnt_next;
    end
  end

  // Sticky events; a new event outweighs a write-one clear in one cycle.
  // Mode events are raised even with automatic gating off, so software
  // still sees every power transition of the processor.
  assign ev_mode = (mode_now != mode_reg);

  always_comb begin
    ev_set                = 2'h0;
    ev_set[PCGS_EV_FAULT] = ev_fault;
    ev_set[PCGS_EV_MODE]  = ev_mode;
    irq_stat_next         = (irq_stat_reg & ~ev_clr) | ev_set;
    irq_next              = |(irq_stat_next & irq_mask_reg);
  end

  // Status and interrupt line registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_stat_reg <= PCGS_EV_RESET;
      irq_reg      <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_reg      <= irq_next;
    end
  end

  // All outputs come straight from flip-flops,
  // so nothing downstream sees a combinational glitch
  assign pready       = pready_reg;
  assign prdata       = prdata_reg;
  assign pslverr      = pslverr_reg;
  assign periph_fault = fault_reg;
  assign unit_clk_en  = en_reg;
  assign irq          = irq_reg;

endmodule : pcgs_clock_gate

// File: test/pcgs_chk_asserts.sv
// Port assertions for the peripheral clock gating controller
`timescale 1ns/10ps
module pcgs_chk
  import pcgs_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // APB
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  // Mode and unit access
  input wire logic        sleep_mode_in,
  input wire logic        deep_sleep_mode_in,
  input wire pcgs_req_t   periph_req,
  input wire logic        periph_fault,
  input wire logic [5:0]  unit_clk_en
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // Mode inputs quiet long enough for the synchroniser to settle
  sequence calm_s;
    $stable({sleep_mode_in, deep_sleep_mode_in})[*5];
  endsequence
  sequence run_s;
    (!sleep_mode_in && !deep_sleep_mode_in)[*5];
  endsequence
  // Committed write to the run gating register
  sequence wr_run_s;
    psel && penable && pready && pwrite && paddr == PCGS_OFF_RUN_GATE;
  endsequence

  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_fault_gated: assert property (
    periph_req.valid && (periph_req.unit > 3'h5 ||
      !unit_clk_en[periph_req.unit]) |=> periph_fault)
    else $error("gated access not faulted");
  chk_fault_clean: assert property (
    periph_req.valid && periph_req.unit < 3'h6 &&
      unit_clk_en[periph_req.unit] |=> !periph_fault)
    else $error("clocked access faulted");
  chk_fault_cause: assert property (
    periph_fault |-> $past(periph_req.valid))
    else $error("fault without request");
  chk_resv_zero: assert property (
    pready && !pwrite && (paddr == PCGS_OFF_RUN_GATE ||
      paddr == PCGS_OFF_SLEEP_GATE || paddr == PCGS_OFF_DEEP_GATE)
      |-> (prdata & 32'hffffdfe0) == 32'h0)
    else $error("reserved gating bits not zero");
  chk_reset_zero: assert property (
    $rose(resetn) |-> unit_clk_en == 6'h00)
    else $error("enables not clear after reset");
  // A committed run write reaches the enables two edges later
  property run_write_p;
    logic [31:0] d;
    run_s ##0 (wr_run_s, d = pwdata) |->
      ##2 unit_clk_en == {d[13], d[4:0]};
  endproperty

  chk_run_write: assert property (run_write_p)
    else $error("run register not applied");
  chk_en_cause: assert property (
    calm_s ##1 !$stable(unit_clk_en) |->
      $past(psel && penable && pwrite && pready, 2))
    else $error("enables moved without cause");
endmodule : pcgs_chk

bind pcgs_clock_gate pcgs_chk chk_u (
  .clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .sleep_mode_in(sleep_mode_in),
  .deep_sleep_mode_in(deep_sleep_mode_in), .periph_req(periph_req),
  .periph_fault(periph_fault), .unit_clk_en(unit_clk_en));

// File: test/tb.sv
// Self-checking bench for the peripheral clock gating controller
`timescale 1ns/10ps
module tb
  import pcgs_pkg::*;
;
  logic        clk_sys, resetn, psel, penable, pwrite;
  logic        pready, pslverr, periph_fault, irq, last_wr;
  logic        sleep_mode_in, deep_sleep_mode_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [5:0]  unit_clk_en;
  pcgs_req_t   periph_req;
  logic [32:0] expq[$];
  int          miscompares, checks;

  pcgs_clock_gate dut_u (
    .clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sleep_mode_in(sleep_mode_in),
    .deep_sleep_mode_in(deep_sleep_mode_in), .periph_req(periph_req),
    .periph_fault(periph_fault), .unit_clk_en(unit_clk_en), .irq(irq));

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic test_done();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  // One APB transfer; a read notes its expected {pslverr, prdata}
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d, input logic [32:0] e);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    if (!w) expq.push_back(e);
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Let n edges land, then sample 1 ns after the last one
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : settle

  // One-cycle access request; fault answer comes one edge later
  task automatic preq(input logic [2:0] u, input logic e);
    logic wb;
    wb = 1'($urandom);
    @(posedge clk_sys);
    periph_req <= '{1'b1, wb, u};
    last_wr = wb;
    @(posedge clk_sys);
    periph_req.valid <= 1'b0;
    #1;
    cmp(33'(periph_fault), 33'(e));
  endtask : preq

  // Read answers matched against the oldest note
  always @(posedge clk_sys) begin
    if (pready === 1'b1 && pwrite === 1'b0) begin
      if (expq.size() == 0) cmp(33'h0, 33'h1);
      else cmp({pslverr, prdata}, expq.pop_front());
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Watchdog sized well beyond the few hundred cycles used
  initial begin
    #1000000;
    miscompares++;
    test_done();
  end

  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sleep_mode_in = 1'b0;
    deep_sleep_mode_in = 1'b0;
    periph_req = '0;
    miscompares = 0;
    checks = 0;
    void'($urandom(12));
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    settle(1);
    cmp(33'(unit_clk_en), 33'h0);
    // Reset values, then an unmapped hole that must be refused
    apb(PCGS_OFF_RUN_GATE, 1'b0, 32'h0, 33'h0);
    apb(PCGS_OFF_SLEEP_GATE, 1'b0, 32'h0, 33'h0);
    apb(PCGS_OFF_DEEP_GATE, 1'b0, 32'h0, 33'h0);
    apb(12'h10c, 1'b0, 32'h0, {1'b1, 32'h0});
    // Walk one enable at a time with reserved bits also written
    for (int i = 0; i < 6; i++) begin
      rv = (i == 5) ? 32'h00002000 : (32'h1 << i);
      apb(PCGS_OFF_RUN_GATE, 1'b1, rv | 32'hffffc000, 33'h0);
      settle(2);
      cmp(33'(unit_clk_en), 33'(6'h1 << i));
      for (int u = 0; u < 8; u++) preq(3'(u), u != i);
    end
    // Six walks of seven faults each; the last one hit code 7
    apb(PCGS_OFF_FAULT_INFO, 1'b0, 32'h0,
        {17'h0, 8'h2a, 3'h0, last_wr, 1'b0, 3'h7});
    // Random run values: readback masked, enables follow
    repeat (8) begin
      rv = $urandom;
      apb(PCGS_OFF_RUN_GATE, 1'b1, rv, 33'h0);
      apb(PCGS_OFF_RUN_GATE, 1'b0, 32'h0, {1'b0, rv & 32'h201f});
      settle(0);
      cmp(33'(unit_clk_en), {27'h0, rv[13], rv[4:0]});
    end
    // Fault event is sticky; masked it stays quiet
    cmp(33'(irq), 33'h0);
    apb(PCGS_OFF_IRQ_STAT, 1'b0, 32'h0, 33'h1);
    apb(PCGS_OFF_IRQ_MASK, 1'b1, 32'h1, 33'h0);
    settle(2);
    cmp(33'(irq), 33'h1);
    apb(PCGS_OFF_IRQ_STAT, 1'b1, 32'h1, 33'h0);
    settle(2);
    cmp(33'(irq), 33'h0);
    apb(PCGS_OFF_IRQ_STAT, 1'b0, 32'h0, 33'h0);
    // Sleep without automatic gating keeps the run register
    apb(PCGS_OFF_SLEEP_GATE, 1'b1, 32'h00002005, 33'h0);
    apb(PCGS_OFF_DEEP_GATE, 1'b1, 32'h0000000a, 33'h0);
    apb(PCGS_OFF_DEEP_GATE, 1'b0, 32'h0, 33'h0000000a);
    @(posedge clk_sys);
    sleep_mode_in <= 1'b1;
    settle(5);
    cmp(33'(unit_clk_en), {27'h0, rv[13], rv[4:0]});
    apb(PCGS_OFF_RUN_CFG, 1'b1, 32'h08000000, 33'h0);
    settle(2);
    cmp(33'(unit_clk_en), 33'h25);
    apb(PCGS_OFF_ACTIVE, 1'b0, 32'h0, 33'h2d);
    @(posedge clk_sys);
    deep_sleep_mode_in <= 1'b1;
    settle(5);
    cmp(33'(unit_clk_en), 33'h0a);
    @(posedge clk_sys);
    sleep_mode_in <= 1'b0;
    deep_sleep_mode_in <= 1'b0;
    settle(5);
    cmp(33'(unit_clk_en), {27'h0, rv[13], rv[4:0]});
    apb(PCGS_OFF_RUN_CFG, 1'b0, 32'h0, {1'b0, 32'h08000000});
    // Mode changes were logged but stay masked off the interrupt
    apb(PCGS_OFF_IRQ_STAT, 1'b0, 32'h0, 33'h2);
    settle(2);
    cmp(33'(irq), 33'h0);
    test_done();
  end
endmodule : tb
